// file: fcs_params.svh
// Timing counts, command codes and address fields for the flash card host sequencer
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
`define FCS_CLK_NS        5
`define FCS_CYC(ns)       (((ns) + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_RST_LOW_NS    500
`define FCS_RST_LOW_CYC   `FCS_CYC(`FCS_RST_LOW_NS)
`define FCS_RST_DONE_NS   20000
`define FCS_RST_DONE_CYC  `FCS_CYC(`FCS_RST_DONE_NS)
`define FCS_WAKE_NS       500
`define FCS_WAKE_CYC      `FCS_CYC(`FCS_WAKE_NS)
`define FCS_ADD_WIN_NS    50000
`define FCS_ADD_WIN_CYC   `FCS_CYC(`FCS_ADD_WIN_NS)
`define FCS_STROBE_NS     50
`define FCS_STROBE_CYC    `FCS_CYC(`FCS_STROBE_NS)
`define FCS_SETUP_CYC     2
`define FCS_HOLD_CYC      2
`define FCS_BUSY_DLY_CYC  8
`define FCS_CMD_ADDR1     16'h0555
`define FCS_CMD_ADDR2     16'h02aa
`define FCS_CODE_UNLOCK1  8'haa
`define FCS_CODE_UNLOCK2  8'h55
`define FCS_CODE_RESET    8'hf0
`define FCS_CODE_ID       8'h90
`define FCS_CODE_PROG     8'ha0
`define FCS_CODE_ERASE    8'h80
`define FCS_CODE_CHIP     8'h10
`define FCS_CODE_SECT     8'h30
`define FCS_CODE_SUSP     8'hb0
`define FCS_CODE_RESUME   8'h30
`define FCS_SECT_LSB      16
`define FCS_BIT_FLAG_LO   3
`define FCS_BIT_FLAG_HI   11
`endif

// file: fcs_pkg.sv
// Types shared by the flash card host sequencer
package fcs_pkg;
  typedef enum logic [3:0] {
    FCS_OP_READ   = 4'h0,
    FCS_OP_POLL   = 4'h1,
    FCS_OP_RESET  = 4'h2,
    FCS_OP_ID     = 4'h3,
    FCS_OP_PROG   = 4'h4,
    FCS_OP_CHIP   = 4'h5,
    FCS_OP_SECT   = 4'h6,
    FCS_OP_SADD   = 4'h7,
    FCS_OP_SUSP   = 4'h8,
    FCS_OP_RESUME = 4'h9,
    FCS_OP_HWRST  = 4'ha
  } fcs_op_t;

  typedef enum logic [2:0] {
    FCS_S_IDLE  = 3'h0,
    FCS_S_WR    = 3'h1,
    FCS_S_RD    = 3'h2,
    FCS_S_BDLY  = 3'h3,
    FCS_S_BUSY  = 3'h4,
    FCS_S_RLO   = 3'h5,
    FCS_S_RWAIT = 3'h6,
    FCS_S_WAKE  = 3'h7
  } fcs_state_t;

  typedef enum logic [1:0] {
    FCS_C_IDLE  = 2'h0,
    FCS_C_SETUP = 2'h1,
    FCS_C_STRB  = 2'h2,
    FCS_C_HOLD  = 2'h3
  } fcs_cstate_t;
endpackage

// file: fcs_cyc_if.sv
// One bus cycle request between the sequencer and the pin engine
`timescale 1ns/1ps
`default_nettype none
interface fcs_cyc_if;
  logic        req;
  logic        wr;
  logic        word;
  logic        hi;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;
  modport seq (output req, wr, word, hi, addr, wdata, input ack, rdata);
  modport eng (input req, wr, word, hi, addr, wdata, output ack, rdata);
endinterface
`default_nettype wire

// file: fcs_cycle.sv
// Pin engine: runs one card read or write cycle with fixed setup, strobe and hold
`timescale 1ns/1ps
`default_nettype none
`include "fcs_params.svh"
module fcs_cycle (
  input  wire logic   mclk,
  input  wire logic   rst_b,
  input  wire logic   ce,
  fcs_cyc_if.eng      cyc,
  output logic [21:0] card_addr,
  output logic [15:0] card_dout,
  output logic        card_d_oe_n,
  input  wire logic [15:0] card_din,
  output logic        low_byte_select_n,
  output logic        high_byte_select_n,
  output logic        card_oe_n,
  output logic        card_we_n
);
  typedef struct packed {
    fcs_pkg::fcs_cstate_t st;
    logic [3:0]           cnt;
    logic                 wr;
    logic [21:0]          addr;
    logic [15:0]          dout;
    logic                 d_oe_n;
    logic                 sel_lo_n;
    logic                 sel_hi_n;
    logic                 oe_n;
    logic                 we_n;
    logic                 ack;
    logic [15:0]          rdata;
  } fcs_cyc_st_t;

  fcs_cyc_st_t s;
  fcs_cyc_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    case (s.st)
      fcs_pkg::FCS_C_IDLE: begin
        // Ack gates req so a held request is not taken twice
        if (cyc.req && !s.ack) begin
          next_s.wr = cyc.wr;
          next_s.addr = cyc.addr;
          next_s.dout = cyc.wdata;
          next_s.sel_lo_n = !(cyc.word || !cyc.hi);
          next_s.sel_hi_n = !(cyc.word || cyc.hi);
          next_s.d_oe_n = !cyc.wr;
          next_s.cnt = 4'(`FCS_SETUP_CYC - 1);
          next_s.st = fcs_pkg::FCS_C_SETUP;
        end
      end
      fcs_pkg::FCS_C_SETUP: begin
        next_s.cnt = s.cnt - 4'h1;
        if (s.cnt == 4'h0) begin
          next_s.we_n = !s.wr;
          next_s.oe_n = s.wr;
          next_s.cnt = 4'(`FCS_STROBE_CYC - 1);
          next_s.st = fcs_pkg::FCS_C_STRB;
        end
      end
      fcs_pkg::FCS_C_STRB: begin
        next_s.cnt = s.cnt - 4'h1;
        if (s.cnt == 4'h0) begin
          if (!s.wr) begin
            next_s.rdata = card_din;
          end
          next_s.we_n = 1'b1;
          next_s.oe_n = 1'b1;
          next_s.cnt = 4'(`FCS_HOLD_CYC - 1);
          next_s.st = fcs_pkg::FCS_C_HOLD;
        end
      end
      fcs_pkg::FCS_C_HOLD: begin
        next_s.cnt = s.cnt - 4'h1;
        if (s.cnt == 4'h0) begin
          next_s.sel_lo_n = 1'b1;
          next_s.sel_hi_n = 1'b1;
          next_s.d_oe_n = 1'b1;
          next_s.ack = 1'b1;
          next_s.st = fcs_pkg::FCS_C_IDLE;
        end
      end
      default: next_s.st = fcs_pkg::FCS_C_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{st: fcs_pkg::FCS_C_IDLE, cnt: 4'h0, wr: 1'b0, addr: 22'h00_0000, dout: 16'h0000,
             d_oe_n: 1'b1, sel_lo_n: 1'b1, sel_hi_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
             ack: 1'b0, rdata: 16'h0000};
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign cyc.ack = s.ack;
  assign cyc.rdata = s.rdata;
  assign card_addr = s.addr;
  assign card_dout = s.dout;
  assign card_d_oe_n = s.d_oe_n;
  assign low_byte_select_n = s.sel_lo_n;
  assign high_byte_select_n = s.sel_hi_n;
  assign card_oe_n = s.oe_n;
  assign card_we_n = s.we_n;
endmodule
`default_nettype wire

// file: fcs_host.sv
// Host sequencer that issues flash card command sequences and tracks erase state
`timescale 1ns/1ps
`default_nettype none
`include "fcs_params.svh"
// How it works
// - Byte mode asserts exactly one select
// - Commands only through write cycles
// - Extra sectors added within 50 us
// - Poll status inside an erasing sector
// - Allow 500 ns wake after reset
module fcs_host #(
  parameter int ADD_WIN_CYC = `FCS_ADD_WIN_CYC
) (
  input  wire logic            mclk,
  input  wire logic            rst_b,
  input  wire logic            ce,
  input  wire logic            cmd_valid,
  input  wire fcs_pkg::fcs_op_t cmd_op,
  input  wire logic [21:0]     cmd_addr,
  input  wire logic [15:0]     cmd_data,
  input  wire logic            cmd_word,
  input  wire logic            cmd_hi,
  output logic                 cmd_ready,
  output logic                 done,
  output logic                 refused,
  output logic [15:0]          rd_data,
  output logic                 window_open,
  output logic                 erasing,
  output logic                 suspended,
  output logic                 id_mode,
  output logic                 erase_window_flag_low,
  output logic                 erase_window_flag_high,
  output logic [21:0]          card_addr,
  output logic [15:0]          card_dout,
  output logic                 card_d_oe_n,
  input  wire logic [15:0]     card_din,
  output logic                 low_byte_select_n,
  output logic                 high_byte_select_n,
  output logic                 card_oe_n,
  output logic                 card_we_n,
  output logic                 card_reset_n,
  input  wire logic            busy_n
);
  if (ADD_WIN_CYC < 2 || ADD_WIN_CYC > 16383) begin : g_chk
    $error("ADD_WIN_CYC out of range");
  end

  function automatic logic [37:0] fcs_step(input fcs_pkg::fcs_op_t op, input logic [2:0] idx,
                                           input logic [21:0] ua, input logic [15:0] ud);
    logic [21:0] a1;
    logic [21:0] a2;
    logic [7:0]  b;
    logic [21:0] a;
    a1 = {ua[21:16], `FCS_CMD_ADDR1};
    a2 = {ua[21:16], `FCS_CMD_ADDR2};
    a = a1;
    b = `FCS_CODE_RESET;
    case (op)
      fcs_pkg::FCS_OP_RESET:  a = ua;
      fcs_pkg::FCS_OP_SADD:   begin a = ua; b = `FCS_CODE_SECT; end
      fcs_pkg::FCS_OP_SUSP:   begin a = ua; b = `FCS_CODE_SUSP; end
      fcs_pkg::FCS_OP_RESUME: begin a = ua; b = `FCS_CODE_RESUME; end
      default: begin
        if (idx == 3'h0 || idx == 3'h3) begin
          b = `FCS_CODE_UNLOCK1;
        end else if (idx == 3'h1 || idx == 3'h4) begin
          a = a2;
          b = `FCS_CODE_UNLOCK2;
        end else if (idx == 3'h2) begin
          b = (op == fcs_pkg::FCS_OP_ID) ? `FCS_CODE_ID :
              (op == fcs_pkg::FCS_OP_PROG) ? `FCS_CODE_PROG : `FCS_CODE_ERASE;
        end else if (op == fcs_pkg::FCS_OP_CHIP) begin
          b = `FCS_CODE_CHIP;
        end else begin
          a = ua;
          b = `FCS_CODE_SECT;
        end
      end
    endcase
    // Program data goes out as given
    if (op == fcs_pkg::FCS_OP_PROG && idx == 3'h3) begin
      fcs_step = {ua, ud};
    end else begin
      fcs_step = {a, b, b};
    end
  endfunction

  function automatic logic [2:0] fcs_nsteps(input fcs_pkg::fcs_op_t op);
    case (op)
      fcs_pkg::FCS_OP_ID:   fcs_nsteps = 3'h3;
      fcs_pkg::FCS_OP_PROG: fcs_nsteps = 3'h4;
      fcs_pkg::FCS_OP_CHIP: fcs_nsteps = 3'h6;
      fcs_pkg::FCS_OP_SECT: fcs_nsteps = 3'h6;
      default:              fcs_nsteps = 3'h1;
    endcase
  endfunction

  typedef struct packed {
    fcs_pkg::fcs_state_t st;
    fcs_pkg::fcs_op_t    op;
    logic [21:0]         addr;
    logic [15:0]         data;
    logic                word;
    logic                hi;
    logic [2:0]          step;
    logic [13:0]         cnt;
    logic [13:0]         wcnt;
    logic [3:0]          ecnt;
    logic [21:0]         sect_addr;
    logic                window;
    logic                erasing;
    logic                suspended;
    logic                id_mode;
    logic                rdy;
    logic                done;
    logic                refused;
    logic [15:0]         rdata;
    logic                flag_lo;
    logic                flag_hi;
    logic                req;
    logic                reset_n;
  } fcs_host_st_t;

  fcs_host_st_t s;
  fcs_host_st_t next_s;
  fcs_cyc_if    cyc ();
  logic [37:0]  step_word;

  always_comb begin
    logic        blocked;
    blocked = 1'b0;
    next_s = s;
    next_s.done = 1'b0;
    next_s.refused = 1'b0;
    if (s.window) begin
      next_s.wcnt = s.wcnt + 14'h1;
      if (s.wcnt == 14'(ADD_WIN_CYC - 1)) begin
        next_s.window = 1'b0;
        next_s.erasing = 1'b1;
        next_s.ecnt = 4'h0;
      end
    end
    if (s.erasing && !s.window && !s.suspended) begin
      if (s.ecnt != 4'(`FCS_BUSY_DLY_CYC)) begin
        next_s.ecnt = s.ecnt + 4'h1;
      end else if (busy_n) begin
        next_s.erasing = 1'b0;
      end
    end
    case (s.st)
      fcs_pkg::FCS_S_IDLE: begin
        if (cmd_valid && s.rdy) begin
          next_s.op = cmd_op;
          next_s.addr = cmd_addr;
          next_s.data = cmd_data;
          next_s.word = cmd_word;
          next_s.hi = cmd_hi;
          next_s.step = 3'h0;
          // Refuse commands that clash with the erase window, erase or suspend state
          case (cmd_op)
            fcs_pkg::FCS_OP_READ, fcs_pkg::FCS_OP_POLL, fcs_pkg::FCS_OP_HWRST: blocked = 1'b0;
            fcs_pkg::FCS_OP_SADD:   blocked = !s.window;
            fcs_pkg::FCS_OP_SUSP:   blocked = !(s.window || (s.erasing && !s.suspended));
            fcs_pkg::FCS_OP_RESUME: blocked = !s.suspended;
            fcs_pkg::FCS_OP_PROG:   blocked = s.window || (s.erasing && !s.suspended);
            default:                blocked = s.window || s.erasing;
          endcase
          if (blocked) begin
            next_s.refused = 1'b1;
          end else if (cmd_op == fcs_pkg::FCS_OP_HWRST) begin
            // Reset pin low for the pulse time
            next_s.rdy = 1'b0;
            next_s.reset_n = 1'b0;
            next_s.cnt = 14'(`FCS_RST_LOW_CYC - 1);
            next_s.st = fcs_pkg::FCS_S_RLO;
          end else begin
            if (cmd_op == fcs_pkg::FCS_OP_POLL) begin
              next_s.addr = s.sect_addr;
            end
            next_s.rdy = 1'b0;
            next_s.req = 1'b1;
            next_s.st = (cmd_op == fcs_pkg::FCS_OP_READ || cmd_op == fcs_pkg::FCS_OP_POLL) ?
                        fcs_pkg::FCS_S_RD : fcs_pkg::FCS_S_WR;
          end
        end
      end
      fcs_pkg::FCS_S_WR: begin
        if (cyc.ack) begin
          next_s.step = s.step + 3'h1;
          if (s.step + 3'h1 == fcs_nsteps(s.op)) begin
            next_s.req = 1'b0;
            next_s.cnt = 14'(`FCS_BUSY_DLY_CYC);
            case (s.op)
              fcs_pkg::FCS_OP_PROG, fcs_pkg::FCS_OP_CHIP: next_s.st = fcs_pkg::FCS_S_BDLY;
              fcs_pkg::FCS_OP_SECT, fcs_pkg::FCS_OP_SADD: begin
                next_s.window = 1'b1;
                next_s.wcnt = 14'h0000;
                next_s.sect_addr = s.addr;
              end
              fcs_pkg::FCS_OP_SUSP: begin
                // Suspend closes the window at once
                next_s.window = 1'b0;
                next_s.erasing = 1'b1;
                next_s.suspended = 1'b1;
              end
              fcs_pkg::FCS_OP_RESUME: begin
                next_s.suspended = 1'b0;
                next_s.ecnt = 4'h0;
              end
              fcs_pkg::FCS_OP_ID:    next_s.id_mode = 1'b1;
              fcs_pkg::FCS_OP_RESET: next_s.id_mode = 1'b0;
              default: next_s.id_mode = s.id_mode;
            endcase
            if (s.op != fcs_pkg::FCS_OP_PROG && s.op != fcs_pkg::FCS_OP_CHIP) begin
              next_s.done = 1'b1;
              next_s.rdy = 1'b1;
              next_s.st = fcs_pkg::FCS_S_IDLE;
            end
          end
        end
      end
      fcs_pkg::FCS_S_RD: begin
        if (cyc.ack) begin
          next_s.req = 1'b0;
          next_s.rdata = cyc.rdata;
          if (s.op == fcs_pkg::FCS_OP_POLL) begin
            next_s.flag_lo = cyc.rdata[`FCS_BIT_FLAG_LO];
            next_s.flag_hi = cyc.rdata[`FCS_BIT_FLAG_HI];
          end
          next_s.done = 1'b1;
          next_s.rdy = 1'b1;
          next_s.st = fcs_pkg::FCS_S_IDLE;
        end
      end
      fcs_pkg::FCS_S_BDLY: begin
        // Busy may lag the last strobe, so wait before trusting it
        next_s.cnt = s.cnt - 14'h1;
        if (s.cnt == 14'h0) begin
          next_s.st = fcs_pkg::FCS_S_BUSY;
        end
      end
      fcs_pkg::FCS_S_BUSY: begin
        if (busy_n) begin
          next_s.done = 1'b1;
          next_s.rdy = 1'b1;
          next_s.st = fcs_pkg::FCS_S_IDLE;
        end
      end
      fcs_pkg::FCS_S_RLO: begin
        next_s.cnt = s.cnt - 14'h1;
        if (s.cnt == 14'h0) begin
          next_s.reset_n = 1'b1;
          next_s.cnt = 14'(`FCS_RST_DONE_CYC - `FCS_RST_LOW_CYC - 1);
          next_s.st = fcs_pkg::FCS_S_RWAIT;
        end
      end
      fcs_pkg::FCS_S_RWAIT: begin
        next_s.cnt = s.cnt - 14'h1;
        if (s.cnt == 14'h0) begin
          next_s.cnt = 14'(`FCS_WAKE_CYC - 1);
          next_s.st = fcs_pkg::FCS_S_WAKE;
        end
      end
      fcs_pkg::FCS_S_WAKE: begin
        next_s.cnt = s.cnt - 14'h1;
        if (s.cnt == 14'h0) begin
          next_s.window = 1'b0;
          next_s.erasing = 1'b0;
          next_s.suspended = 1'b0;
          next_s.id_mode = 1'b0;
          next_s.done = 1'b1;
          next_s.rdy = 1'b1;
          next_s.st = fcs_pkg::FCS_S_IDLE;
        end
      end
      default: next_s.st = fcs_pkg::FCS_S_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.rdy <= 1'b1;
      s.reset_n <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign cyc.req = s.req;
  assign cyc.wr = (s.st == fcs_pkg::FCS_S_WR);
  assign cyc.word = s.word;
  assign cyc.hi = s.hi;
  assign step_word = fcs_step(s.op, s.step, s.addr, s.data);
  assign cyc.addr = (s.st == fcs_pkg::FCS_S_WR) ? step_word[37:16] : s.addr;
  assign cyc.wdata = step_word[15:0];

  fcs_cycle u_cycle (
    .mclk               (mclk),
    .rst_b              (rst_b),
    .ce                 (ce),
    .cyc                (cyc),
    .card_addr          (card_addr),
    .card_dout          (card_dout),
    .card_d_oe_n        (card_d_oe_n),
    .card_din           (card_din),
    .low_byte_select_n  (low_byte_select_n),
    .high_byte_select_n (high_byte_select_n),
    .card_oe_n          (card_oe_n),
    .card_we_n          (card_we_n)
  );

  assign cmd_ready = s.rdy;
  assign done = s.done;
  assign refused = s.refused;
  assign rd_data = s.rdata;
  assign window_open = s.window;
  assign erasing = s.erasing;
  assign suspended = s.suspended;
  assign id_mode = s.id_mode;
  assign erase_window_flag_low = s.flag_lo;
  assign erase_window_flag_high = s.flag_hi;
  assign card_reset_n = s.reset_n;
endmodule
`default_nettype wire

// file: fcs_host_monitor.sv
// Checker of the host sequencer port and pin timing
`timescale 1ns/1ps
`default_nettype none
module fcs_host_monitor (
  input wire logic             mclk,
  input wire logic             rst_b,
  input wire logic             ce,
  input wire logic             cmd_valid,
  input wire fcs_pkg::fcs_op_t cmd_op,
  input wire logic             cmd_ready,
  input wire logic             done,
  input wire logic             refused,
  input wire logic             window_open,
  input wire logic             suspended,
  input wire logic             card_d_oe_n,
  input wire logic             low_byte_select_n,
  input wire logic             high_byte_select_n,
  input wire logic             card_oe_n,
  input wire logic             card_we_n,
  input wire logic             card_reset_n
);
  logic take;
  int   low_cnt;
  int   since_rst;
  assign take = cmd_valid && cmd_ready && ce;
  // since_rst saturates at 1000 so long runs cannot wrap
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt   <= 0;
      since_rst <= 1000;
    end else begin
      low_cnt   <= card_reset_n ? 0 : low_cnt + 1;
      since_rst <= !card_reset_n ? 0 : (since_rst < 1000 ? since_rst + 1 : since_rst);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  AST_WRITE_CYCLE: assert property (!card_we_n |-> card_oe_n && !(low_byte_select_n && high_byte_select_n))
    else $error("write strobe without select or with output enable");
  AST_HOST_FLOAT: assert property (!card_oe_n |-> card_d_oe_n)
    else $error("host drives data during a read");
  AST_READ_SEL: assert property (!card_oe_n |-> card_we_n && !(low_byte_select_n && high_byte_select_n))
    else $error("read strobe without select");
  AST_STROBE_WIDTH: assert property ($fell(card_we_n) |-> !card_we_n [*8])
    else $error("write strobe too short");
  AST_RESET_WIDTH: assert property ($rose(card_reset_n) |-> low_cnt >= 100)
    else $error("card reset pulse too short");
  AST_WAKE: assert property (!card_oe_n |-> since_rst >= 100)
    else $error("read too soon after card reset");
  AST_SADD_REFUSE: assert property (take && cmd_op == fcs_pkg::FCS_OP_SADD && !window_open |=> refused)
    else $error("late sector addition not refused");
  AST_RESUME_REFUSE: assert property (take && cmd_op == fcs_pkg::FCS_OP_RESUME && !suspended |=> refused)
    else $error("resume without suspend not refused");
  AST_SUSP_WINDOW: assert property (suspended |-> !window_open)
    else $error("window open while suspended");
  AST_READ_DONE: assert property (take && cmd_op == fcs_pkg::FCS_OP_READ |-> ##17 done)
    else $error("read not done in 17 cycles");
endmodule
bind fcs_host fcs_host_monitor u_mon (
  .mclk(mclk), .rst_b(rst_b), .ce(ce), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready),
  .done(done), .refused(refused), .window_open(window_open), .suspended(suspended), .card_d_oe_n(card_d_oe_n),
  .low_byte_select_n(low_byte_select_n), .high_byte_select_n(high_byte_select_n), .card_oe_n(card_oe_n),
  .card_we_n(card_we_n), .card_reset_n(card_reset_n));
`default_nettype wire

// file: fcs_card_model.sv
// Behavioural flash card answering the host pins
`timescale 1ns/1ps
`default_nettype none
module fcs_card_model #(
  // Identity codes are arbitrary
  parameter logic [15:0] MFR_CODE = 16'h005a,
  parameter logic [15:0] DEV_CODE = 16'h00a5
) (
  input  wire logic        mclk,
  input  wire logic        card_reset_n,
  input  wire logic        card_oe_n,
  input  wire logic        card_we_n,
  input  wire logic        low_byte_select_n,
  input  wire logic        high_byte_select_n,
  input  wire logic [21:0] card_addr,
  input  wire logic [15:0] card_dout,
  output logic      [15:0] card_din,
  output logic             busy_n
);
  logic [15:0] mem [logic [21:0]];
  logic [21:0] kq [$];
  logic [7:0]  hist [$];
  logic        we_q = 1'b1;
  logic        write_lock_switch = 1'b0;
  logic        id_on = 1'b0;
  logic        sect = 1'b0;
  logic        susp = 1'b0;
  int          busy = 0;
  int          n;
  initial card_din = 16'h0000;
  assign busy_n = (busy == 0) || susp;
  always @(posedge mclk) begin
    we_q <= card_we_n;
    if (!card_reset_n) begin
      hist = {};
      id_on = 0;
      busy = 0;
      susp = 0;
    end else if (busy > 0 && !susp) busy = busy - 1;
    if (card_reset_n && card_we_n && !we_q && (busy == 0 || sect) && !write_lock_switch) begin
      hist.push_back(card_dout[7:0]);
      n = hist.size();
      if (sect && busy > 0) begin
        susp = (hist[n-1] == 8'hb0);
        hist = {};
      end else if ((hist[n-1] == 8'hf0 && !(n == 4 && hist[2] == 8'ha0)) || hist[0] != 8'haa ||
                   (n > 1 && hist[1] != 8'h55)) begin
        id_on = id_on && hist[n-1] != 8'hf0;
        hist = {};
      end else if (n == 3 && hist[2] == 8'h90) begin
        id_on = 1;
        hist = {};
      end else if (n == 4 && hist[2] == 8'ha0) begin
        mem[card_addr] = (mem.exists(card_addr) ? mem[card_addr] : 16'hffff) & card_dout;
        busy = 40;
        hist = {};
      end else if (n == 6) begin
        kq = {};
        foreach (mem[k]) if (hist[5] == 8'h10 || k[21:16] == card_addr[21:16]) kq.push_back(k);
        foreach (kq[i]) mem.delete(kq[i]);
        busy = (hist[5] == 8'h10) ? 60 : 500;
        sect = (hist[5] == 8'h30);
        hist = {};
      end
    end
    if (card_reset_n && !card_oe_n && !(low_byte_select_n && high_byte_select_n))
      card_din <= id_on ? (card_addr[0] ? DEV_CODE : MFR_CODE) : (sect && busy > 0 && !susp) ? 16'h0808 :
                  (mem.exists(card_addr) ? mem[card_addr] : 16'hffff);
    else card_din <= ~card_din;
  end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the host sequencer against a card model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  `define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
  localparam logic [15:0] MFR = 16'h005a;
  localparam logic [15:0] DEV = 16'h00a5;
  logic             mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, cmd_valid = 1'b0, cmd_word = 1'b1, cmd_hi = 1'b0;
  fcs_pkg::fcs_op_t cmd_op = fcs_pkg::FCS_OP_READ;
  logic [21:0]      cmd_addr = 22'h00_0000, card_addr, a;
  logic [15:0]      cmd_data = 16'h0000, card_din, rd_data, card_dout;
  logic             cmd_ready, done, refused, window_open, erasing, suspended, id_mode, fl_lo, fl_hi;
  logic             d_oe_n, lbs_n, hbs_n, oe_n, we_n, rstn_c, busy_n, res;
  logic [1:0]       sel;
  logic [31:0]      seed = 32'h0000_4b22, t;
  int               mismatches = 0, tests_run = 0, cycles = 0;
  logic [15:0]      bm [logic [21:0]];
  always #2.5 mclk = ~mclk;
  fcs_host #(.ADD_WIN_CYC(200)) dut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_word(cmd_word), .cmd_hi(cmd_hi), .cmd_ready(cmd_ready),
    .done(done), .refused(refused), .rd_data(rd_data), .window_open(window_open), .erasing(erasing),
    .suspended(suspended), .id_mode(id_mode), .erase_window_flag_low(fl_lo), .erase_window_flag_high(fl_hi),
    .card_addr(card_addr), .card_dout(card_dout), .card_d_oe_n(d_oe_n), .card_din(card_din),
    .low_byte_select_n(lbs_n), .high_byte_select_n(hbs_n), .card_oe_n(oe_n), .card_we_n(we_n),
    .card_reset_n(rstn_c), .busy_n(busy_n));
  fcs_card_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) card (.mclk(mclk), .card_reset_n(rstn_c), .card_oe_n(oe_n),
    .card_we_n(we_n), .low_byte_select_n(lbs_n), .high_byte_select_n(hbs_n), .card_addr(card_addr),
    .card_dout(card_dout), .card_din(card_din), .busy_n(busy_n));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Whole run needs about 6300 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic run(input fcs_pkg::fcs_op_t op, input logic [21:0] ad, input logic [15:0] d, input logic w,
                     input logic h);
    @(posedge mclk);
    #1;
    {cmd_valid, cmd_op, cmd_addr, cmd_data, cmd_word, cmd_hi} = {1'b1, op, ad, d, w, h};
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    sel = 2'b11;
    while (done !== 1'b1 && refused !== 1'b1) begin
      if (oe_n === 1'b0 || we_n === 1'b0) sel = {hbs_n, lbs_n};
      @(posedge mclk);
      #1;
    end
    res = refused;
  endtask
  task automatic rd(input logic [21:0] ad);
    run(fcs_pkg::FCS_OP_READ, ad, 16'h0000, 1'b1, 1'b0);
    `CHK("rd_data", (bm.exists(ad) ? bm[ad] : 16'hffff), rd_data)
  endtask
  task automatic prog_rd(input logic [21:0] ad, input logic [15:0] d);
    run(fcs_pkg::FCS_OP_PROG, ad, d, 1'b1, 1'b0);
    bm[ad] = (bm.exists(ad) ? bm[ad] : 16'hffff) & d;
    rd(ad);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    `CHK("idle pins", 6'b111111, {cmd_ready, lbs_n, hbs_n, oe_n, we_n, rstn_c})
    for (int i = 0; i < 4; i++) begin
      t = rnd();
      a = {6'h01, t[15:0]};
      t = rnd();
      prog_rd(a, t[15:0]);
      t = rnd();
      prog_rd(a, t[15:0]);
    end
    for (int i = 0; i < 3; i++) begin
      run(fcs_pkg::FCS_OP_READ, a, 16'h0000, i == 2, i == 1);
      `CHK("selects", (i == 2) ? 2'b00 : (i == 1) ? 2'b01 : 2'b10, sel)
    end
    run(fcs_pkg::FCS_OP_ID, 22'h00_0000, 16'h0000, 1'b1, 1'b0);
    run(fcs_pkg::FCS_OP_READ, 22'h00_0001, 16'h0000, 1'b1, 1'b0);
    `CHK("device code", DEV, rd_data)
    run(fcs_pkg::FCS_OP_READ, 22'h00_0000, 16'h0000, 1'b1, 1'b0);
    `CHK("maker code", MFR, rd_data)
    run(fcs_pkg::FCS_OP_RESET, 22'h00_0000, 16'h0000, 1'b1, 1'b0);
    `CHK("id_mode", 1'b0, id_mode)
    rd(a);
    run(fcs_pkg::FCS_OP_SADD, 22'h05_0000, 16'h0000, 1'b1, 1'b0);
    `CHK("late add", 1'b1, res)
    run(fcs_pkg::FCS_OP_RESUME, 22'h05_0000, 16'h0000, 1'b1, 1'b0);
    `CHK("resume", 1'b1, res)
    prog_rd(22'h03_0010, 16'h1234);
    run(fcs_pkg::FCS_OP_SECT, 22'h03_0000, 16'h0000, 1'b1, 1'b0);
    `CHK("window", 1'b1, window_open)
    run(fcs_pkg::FCS_OP_SADD, 22'h05_0000, 16'h0000, 1'b1, 1'b0);
    `CHK("add", 1'b0, res)
    run(fcs_pkg::FCS_OP_POLL, 22'h03_0000, 16'h0000, 1'b1, 1'b0);
    `CHK("flags", 2'b11, {fl_hi, fl_lo})
    `CHK("poll sector", 6'h05, card_addr[21:16])
    run(fcs_pkg::FCS_OP_PROG, a, 16'h0000, 1'b1, 1'b0);
    `CHK("prog in window", 1'b1, res)
    run(fcs_pkg::FCS_OP_SUSP, 22'h3f_ffff, 16'h0000, 1'b1, 1'b0);
    `CHK("suspend", 3'b010, {res, suspended, window_open})
    rd(a);
    run(fcs_pkg::FCS_OP_RESUME, 22'h00_0000, 16'h0000, 1'b1, 1'b0);
    `CHK("resumed", 1'b0, suspended)
    for (int i = 0; i < 3000 && erasing !== 1'b0; i++) @(posedge mclk);
    #1;
    `CHK("erase end", 1'b0, erasing)
    bm.delete(22'h03_0010);
    rd(22'h03_0010);
    run(fcs_pkg::FCS_OP_CHIP, 22'h00_0000, 16'h0000, 1'b1, 1'b0);
    bm.delete();
    rd(a);
    run(fcs_pkg::FCS_OP_ID, 22'h00_0000, 16'h0000, 1'b1, 1'b0);
    run(fcs_pkg::FCS_OP_HWRST, 22'h00_0000, 16'h0000, 1'b1, 1'b0);
    `CHK("id after reset", 1'b0, id_mode)
    rd(22'h00_0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
